// *** verilog/wcr_pkg.sv ***
// constants and types for the wetting current configuration registers
// assumes one core clock and a register access port driven by the serial frame decoder
`default_nettype none

package wcr_pkg;

   // register access port geometry
   localparam int unsigned WCR_ADDR_W = 6;
   localparam int unsigned WCR_DATA_W = 24;

   // register offsets
   localparam logic [5:0] WCR_CFG_A_OFFSET = 6'h1d;
   localparam logic [5:0] WCR_CFG_B_OFFSET = 6'h1e;

   // field positions, low bit of each 3-bit strength field, then the two disable bits
   localparam int unsigned WCR_STRENGTH_W = 3;
   localparam int unsigned WCR_POS_IN0_1 = 0;
   localparam int unsigned WCR_POS_IN2_3 = 3;
   localparam int unsigned WCR_POS_IN23 = 18;
   localparam int unsigned WCR_POS_SRC_DIS = 21;
   localparam int unsigned WCR_POS_SINK_DIS = 22;

   // values after reset
   localparam logic [2:0] WCR_STRENGTH_RST = 3'h0;
   localparam logic WCR_DIS_RST = 1'b0;
   localparam logic [23:0] WCR_RDATA_RST = 24'h000000;
   localparam logic [14:0] WCR_LEVEL_RST = 15'h0000;
   localparam logic [4:0] WCR_SYNC_RST = 5'h00;

   // channels handled here: inputs 0, 1, 2, 3 and 23
   localparam int unsigned WCR_NUM_CH = 5;
   localparam int unsigned WCR_CH_IN23 = 4;
   // inputs with a direction-select bit (the rest are fixed sources)
   localparam int unsigned WCR_NUM_DIR_CH = 4;

   // direction-select encoding
   localparam logic WCR_DIR_SOURCE = 1'b0;
   localparam logic WCR_DIR_SINK = 1'b1;

   // strength codes as stored in the registers
   localparam logic [2:0] WCR_CODE_OFF = 3'h0;
   localparam logic [2:0] WCR_CODE_1MA = 3'h1;
   localparam logic [2:0] WCR_CODE_2MA = 3'h2;
   localparam logic [2:0] WCR_CODE_5MA = 3'h3;
   localparam logic [2:0] WCR_CODE_10MA = 3'h4;

   // decoded current level sent to the current sources
   typedef enum logic [2:0] {
      WCR_LVL_OFF = 3'b000,
      WCR_LVL_1MA = 3'b001,
      WCR_LVL_2MA = 3'b010,
      WCR_LVL_5MA = 3'b011,
      WCR_LVL_10MA = 3'b100,
      WCR_LVL_15MA = 3'b101
   } wcr_level_t;

   // level that 10 mA and 15 mA drop to on switch closure
   localparam wcr_level_t WCR_LVL_SCALED = WCR_LVL_2MA;

endpackage

`default_nettype wire

// *** verilog/wcr_strength_decode.sv ***
// strength code decoder with closure auto-scaling for one input
// assumes all inputs are on the core clock; purely combinational
`timescale 1ns/1ps
`default_nettype none

module wcr_strength_decode (
   input wire logic [2:0] code, // stored strength code
   input wire logic dir_sink, // 1 = input runs as current sink
   input wire logic closed, // synchronised switch closure
   input wire logic sink_dis, // auto-scaling off for sink inputs
   input wire logic src_dis, // auto-scaling off for source inputs
   output wcr_pkg::wcr_level_t level // level for the current source
);
   import wcr_pkg::*;

   wcr_level_t base;
   logic scale_off;

   // code to nominal level; every code above four means 15 mA
   always_comb begin
      unique case (code)
         WCR_CODE_OFF: base = WCR_LVL_OFF;
         WCR_CODE_1MA: base = WCR_LVL_1MA;
         WCR_CODE_2MA: base = WCR_LVL_2MA;
         WCR_CODE_5MA: base = WCR_LVL_5MA;
         WCR_CODE_10MA: base = WCR_LVL_10MA;
         3'h5, 3'h6, 3'h7: base = WCR_LVL_15MA;
      endcase
   end

   // direction picks which disable bit governs this input
   assign scale_off = dir_sink ? sink_dis : src_dis;

   // only the high settings are scaled, and only while the switch is closed
   always_comb begin
      level = base;
      if (closed && !scale_off && (base == WCR_LVL_10MA || base == WCR_LVL_15MA)) begin
         level = WCR_LVL_SCALED;
      end
   end

endmodule

`default_nettype wire

// *** verilog/wcr_regs.sv ***
// wetting current configuration registers with per-input level decode
// assumes the serial frame decoder drives the access port on core_clk,
// and switch closure levels arrive asynchronously from the comparators;
// direction bits come from the register file on the same clock
`timescale 1ns/1ps
`default_nettype none

// Function
// - strength code 0 none, 1 1mA, 2 2mA, 3 5mA, 4 10mA, 5-7 15mA.
// - inputs 2 and 3 share a read/write field, bits 5:3 of word a, reset 0.
// - inputs 0 and 1 share a read/write field, bits 2:0 of word a, reset 0.
// - word b sits at offset 1Eh and resets to all zeros.
// - bit 22 set stops closure scaling of 10/15 mA on sink inputs.
// - bit 21 does the same for inputs running as current sources.
// - input 23 has its own read/write field, bits 20:18 of word b, reset 0.
// - direction bit 0 means source, 1 means sink; picks governing disable bit.
module wcr_regs #(
   parameter int unsigned SYNC_STAGES = 2 // closure synchroniser depth
) (
   input wire logic core_clk, // core clock, 250 MHz
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [5:0] reg_addr, // register offset
   input wire logic reg_wr_en, // write strobe, one cycle
   input wire logic reg_rd_en, // read strobe, one cycle
   input wire logic [23:0] reg_wdata, // write data
   output logic [23:0] reg_rdata, // read data, registered
   output logic reg_rd_valid, // read data valid pulse
   output logic reg_addr_hit, // address belongs to this block
   input wire logic [3:0] current_source_select, // direction bits inputs 0-3
   input wire logic [4:0] switch_closed_pin, // closure, inputs 0,1,2,3,23
   output logic [2:0] strength_inputs_0_1, // stored code, inputs 0/1
   output logic [2:0] strength_inputs_2_3, // stored code, inputs 2/3
   output logic [2:0] strength_input_23, // stored code, input 23
   output logic sink_autoscale_disable, // stored disable, sink inputs
   output logic source_autoscale_disable, // stored disable, source inputs
   output logic [14:0] wet_level // decoded level, 3 bits per channel
);
   import wcr_pkg::*;

   // configuration state
   logic [2:0] str01_r, str01_nxt;
   logic [2:0] str23_r, str23_nxt;
   logic [2:0] str_in23_r, str_in23_nxt;
   logic sink_dis_r, sink_dis_nxt;
   logic src_dis_r, src_dis_nxt;

   // read return state
   logic [23:0] rdata_r, rdata_nxt;
   logic rd_valid_r, rd_valid_nxt;

   // read images of both words
   logic [23:0] word_a_view, word_b_view;

   // closure synchroniser and level outputs
   logic [4:0] sync_r [SYNC_STAGES];
   logic [4:0] sync_nxt [SYNC_STAGES];
   logic [4:0] closed_s;
   logic [14:0] level_r, level_nxt;
   logic hit_a, hit_b;
   logic [2:0] ch_code [WCR_NUM_CH];
   logic [WCR_NUM_CH-1:0] ch_sink;
   wcr_level_t ch_level [WCR_NUM_CH];

   // word a, 0x1d: bits 5:3 inputs 2/3, bits 2:0 inputs 0/1
   // word b, 0x1e: bit 22 sink disable, bit 21 source disable, bits 20:18 input 23
   // nothing else of either word is stored here, so other bits read zero
   // exact offset match; a stray address never touches a field
   assign hit_a = (reg_addr == WCR_CFG_A_OFFSET);
   assign hit_b = (reg_addr == WCR_CFG_B_OFFSET);
   assign reg_addr_hit = hit_a | hit_b;

   // register writes; other addresses leave all fields alone
   // a read in the same cycle still returns the old value
   always_comb begin
      str01_nxt = str01_r;
      str23_nxt = str23_r;
      str_in23_nxt = str_in23_r;
      sink_dis_nxt = sink_dis_r;
      src_dis_nxt = src_dis_r;
      // word a takes only its two pair fields
      if (reg_wr_en && hit_a) begin
         str01_nxt = reg_wdata[WCR_POS_IN0_1 +: WCR_STRENGTH_W];
         str23_nxt = reg_wdata[WCR_POS_IN2_3 +: WCR_STRENGTH_W];
      end
      // only the three fields of word b take data; the rest is dropped
      if (reg_wr_en && hit_b) begin
         str_in23_nxt = reg_wdata[WCR_POS_IN23 +: WCR_STRENGTH_W];
         src_dis_nxt = reg_wdata[WCR_POS_SRC_DIS];
         sink_dis_nxt = reg_wdata[WCR_POS_SINK_DIS];
      end
   end

   // live images of both words; unimplemented bits stay zero
   always_comb begin
      word_a_view = WCR_RDATA_RST;
      word_b_view = WCR_RDATA_RST;
      word_a_view[WCR_POS_IN0_1 +: WCR_STRENGTH_W] = str01_r;
      word_a_view[WCR_POS_IN2_3 +: WCR_STRENGTH_W] = str23_r;
      word_b_view[WCR_POS_IN23 +: WCR_STRENGTH_W] = str_in23_r;
      word_b_view[WCR_POS_SRC_DIS] = src_dis_r;
      word_b_view[WCR_POS_SINK_DIS] = sink_dis_r;
   end

   // read mux; a miss answers zero with valid so the frame never stalls
   always_comb begin
      rdata_nxt = rdata_r;
      rd_valid_nxt = reg_rd_en;
      if (reg_rd_en) begin
         rdata_nxt = WCR_RDATA_RST;
         if (hit_a) begin
            rdata_nxt = word_a_view;
         end
         if (hit_b) begin
            rdata_nxt = word_b_view;
         end
      end
   end

   // register state; everything clears under reset
   // synchronous clear only, the core clock keeps running through reset
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         str01_r <= WCR_STRENGTH_RST;
         str23_r <= WCR_STRENGTH_RST;
         str_in23_r <= WCR_STRENGTH_RST;
         sink_dis_r <= WCR_DIS_RST;
         src_dis_r <= WCR_DIS_RST;
         rdata_r <= WCR_RDATA_RST;
         rd_valid_r <= 1'b0;
      end else begin
         str01_r <= str01_nxt;
         str23_r <= str23_nxt;
         str_in23_r <= str_in23_nxt;
         sink_dis_r <= sink_dis_nxt;
         src_dis_r <= src_dis_nxt;
         rdata_r <= rdata_nxt;
         rd_valid_r <= rd_valid_nxt;
      end
   end

   // outputs straight from the flops, no decode in between
   assign reg_rdata = rdata_r;
   assign reg_rd_valid = rd_valid_r;
   assign strength_inputs_0_1 = str01_r;
   assign strength_inputs_2_3 = str23_r;
   assign strength_input_23 = str_in23_r;
   assign sink_autoscale_disable = sink_dis_r;
   assign source_autoscale_disable = src_dis_r;

   // closure pins are asynchronous; stage one feeds only stage two,
   // so no decode logic ever sees a possibly metastable value
   always_comb begin
      sync_nxt[0] = switch_closed_pin;
      for (int s = 1; s < SYNC_STAGES; s++) begin
         sync_nxt[s] = sync_r[s-1];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         for (int s = 0; s < SYNC_STAGES; s++) begin
            sync_r[s] <= WCR_SYNC_RST;
         end
      end else begin
         for (int s = 0; s < SYNC_STAGES; s++) begin
            sync_r[s] <= sync_nxt[s];
         end
      end
   end

   // only the last stage leaves the synchroniser
   assign closed_s = sync_r[SYNC_STAGES-1];

   // map shared fields onto channels; input 23 is always a source
   // pairs share one code each, since the word has one field per pair
   always_comb begin
      ch_code[0] = str01_r;
      ch_code[1] = str01_r;
      ch_code[2] = str23_r;
      ch_code[3] = str23_r;
      ch_code[WCR_CH_IN23] = str_in23_r;
      ch_sink = {WCR_DIR_SOURCE, current_source_select};
   end

   // one decoder per channel
   // input 23 has no direction bit, so its slot is tied to source mode
   for (genvar c = 0; c < WCR_NUM_CH; c++) begin : g_ch
      wcr_strength_decode u_dec (
         .code(ch_code[c]),
         .dir_sink(ch_sink[c]),
         .closed(closed_s[c]),
         .sink_dis(sink_dis_r),
         .src_dis(src_dis_r),
         .level(ch_level[c])
      );
   end

   // pack levels; registered so the current sources see clean steps
   // the extra cycle is negligible beside switch bounce times
   always_comb begin
      level_nxt = WCR_LEVEL_RST;
      for (int c = 0; c < WCR_NUM_CH; c++) begin
         level_nxt[c*3 +: 3] = ch_level[c];
      end
   end

   // level register; clears with the fields so no current flows after reset
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         level_r <= WCR_LEVEL_RST;
      end else begin
         level_r <= level_nxt;
      end
   end

   // levels leave straight from their register
   assign wet_level = level_r;

endmodule

`default_nettype wire

// *** tb/wcr_regs_asserts.sv ***
// checker for the wetting current register block
// assumes it is bound onto wcr_regs, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module wcr_regs_asserts #(
   parameter int unsigned SYNC_STAGES = 2 // synchroniser depth
) (
   input wire logic core_clk, // clock
   input wire logic rst_n, // reset, active low
   input wire logic [5:0] reg_addr, // offset
   input wire logic reg_wr_en, // write strobe
   input wire logic reg_rd_en, // read strobe
   input wire logic [23:0] reg_wdata, // write data
   input wire logic [23:0] reg_rdata, // read data
   input wire logic reg_rd_valid, // read valid
   input wire logic reg_addr_hit, // decode flag
   input wire logic [3:0] current_source_select, // directions
   input wire logic [4:0] switch_closed_pin, // closures
   input wire logic [2:0] strength_inputs_0_1, // field
   input wire logic [2:0] strength_inputs_2_3, // field
   input wire logic [2:0] strength_input_23, // field
   input wire logic sink_autoscale_disable, // bit 22
   input wire logic source_autoscale_disable, // bit 21
   input wire logic [14:0] wet_level // levels
);
   logic wa, wb, rb;
   // strobes decoded per word
   assign wa = reg_wr_en && reg_addr == 6'h1d;
   assign wb = reg_wr_en && reg_addr == 6'h1e;
   assign rb = reg_rd_en && reg_addr == 6'h1e;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_field_in01: assert property (wa |=> strength_inputs_0_1 == $past(reg_wdata[2:0]))
      else $error("field of inputs 0/1 wrong");
   a_field_in23p: assert property (wa |=> strength_inputs_2_3 == $past(reg_wdata[5:3]))
      else $error("field of inputs 2/3 wrong");
   a_field_in23: assert property (wb |=> strength_input_23 == $past(reg_wdata[20:18]))
      else $error("field of input 23 wrong");
   a_sink_bit: assert property (wb |=> sink_autoscale_disable == $past(reg_wdata[22]))
      else $error("sink disable bit wrong");
   a_src_bit: assert property (wb |=> source_autoscale_disable == $past(reg_wdata[21]))
      else $error("source disable bit wrong");
   a_read_word_b: assert property (rb |=> reg_rd_valid && reg_rdata == {1'b0,
      $past(sink_autoscale_disable), $past(source_autoscale_disable), $past(strength_input_23),
      18'h0}) else $error("word b read wrong");
   a_addr_decode: assert property (reg_addr_hit == (reg_addr == 6'h1d || reg_addr == 6'h1e))
      else $error("address decode wrong");
   a_reset_clear: assert property (disable iff (1'b0) !rst_n |=> strength_input_23 == 3'h0
      && !sink_autoscale_disable && !source_autoscale_disable) else $error("reset value wrong");
   a_plain_level: assert property ((!switch_closed_pin[4] && $stable(strength_input_23))[*4]
      |-> wet_level[14:12] == (strength_input_23 > 3'h4 ? 3'h5 : strength_input_23))
      else $error("decoded level wrong");
   a_sink_scale: assert property ((current_source_select[0] && switch_closed_pin[0]
      && !sink_autoscale_disable && strength_inputs_0_1 == 3'h4)[*4] |-> wet_level[2:0] == 3'h2)
      else $error("sink input not scaled");
   a_src_scale: assert property ((!current_source_select[2] && switch_closed_pin[2]
      && !source_autoscale_disable && strength_inputs_2_3 == 3'h5)[*4] |-> wet_level[8:6] == 3'h2)
      else $error("source input not scaled");
   // main scenarios reached
   c_write_b: cover property (wb);
   c_read_b: cover property (rb);
   c_scaled: cover property (switch_closed_pin[0] && wet_level[2:0] == 3'h2);
endmodule
bind wcr_regs wcr_regs_asserts #(.SYNC_STAGES(SYNC_STAGES)) u_chk (.core_clk(core_clk),
   .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
   .reg_addr_hit(reg_addr_hit),
   .current_source_select(current_source_select), .switch_closed_pin(switch_closed_pin),
   .strength_inputs_0_1(strength_inputs_0_1), .strength_inputs_2_3(strength_inputs_2_3),
   .strength_input_23(strength_input_23), .sink_autoscale_disable(sink_autoscale_disable),
   .source_autoscale_disable(source_autoscale_disable), .wet_level(wet_level));
`default_nettype wire

// *** tb/wcr_regs_tb.sv ***
// self-checking bench for the wetting current register block
// assumes wcr_pkg and wcr_regs compiled first
`timescale 1ns/1ps
`default_nettype none
module wcr_regs_tb;
   import wcr_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] reg_addr = 6'h0;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [23:0] reg_wdata = 24'h0;
   logic [3:0] current_source_select = 4'h0;
   logic [4:0] switch_closed_pin = 5'h0;
   logic [23:0] reg_rdata;
   logic reg_rd_valid;
   logic reg_addr_hit;
   logic [14:0] wet_level;
   int err_count = 0;
   int n_compared = 0;
   int cyc = 0;
   always #2 core_clk = ~core_clk;
   wcr_regs #(.SYNC_STAGES(2)) DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid), .reg_addr_hit(reg_addr_hit),
      .current_source_select(current_source_select),
      .switch_closed_pin(switch_closed_pin), .strength_inputs_0_1(), .strength_inputs_2_3(),
      .strength_input_23(), .sink_autoscale_disable(), .source_autoscale_disable(),
      .wet_level(wet_level));
   task automatic close_out;
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      @(posedge core_clk);
      reg_wr_en <= 1'b0;
   endtask
   // valid and data are looked at in the one cycle valid stands
   task automatic rd(input logic [5:0] a, input logic [23:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge core_clk);
      reg_rd_en <= 1'b0;
      #1;
      chk({23'h0, reg_rd_valid}, 24'h1);
      chk(reg_rdata, exp);
      chk({23'h0, reg_addr_hit}, {23'h0, (a == WCR_CFG_A_OFFSET) || (a == WCR_CFG_B_OFFSET)});
   endtask
   // four edges cover the synchroniser and the level register
   task automatic lvl(input int sh, input logic [2:0] exp);
      repeat (4) @(posedge core_clk);
      #1;
      chk({21'h0, wet_level[sh+:3]}, {21'h0, exp});
   endtask
   // hang guard, far above the expected run length
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         close_out;
      end
   end
   initial begin
      logic [2:0] e;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(6'h1d, 24'h0);
      rd(6'h1e, 24'h0);
      wr(6'h1d, 24'hffffff);
      rd(6'h1d, 24'h00003f);
      wr(6'h1e, 24'hffffff);
      rd(6'h1e, 24'h7c0000);
      rd(6'h1f, 24'h0);
      for (int c = 0; c < 8; c++) begin
         e = (c > 4) ? 3'h5 : 3'(c);
         wr(6'h1e, 24'(c) << 18);
         wr(6'h1d, 24'(c * 9));
         lvl(12, e);
         lvl(9, e);
      end
      // closures with inputs 0/1 sinking, 2/3 sourcing
      wr(6'h1d, 24'h00002c);
      wr(6'h1e, 24'h140000);
      @(posedge core_clk);
      current_source_select <= 4'h3;
      switch_closed_pin <= 5'h1f;
      lvl(0, 3'h2);
      lvl(6, 3'h2);
      lvl(12, 3'h2);
      wr(6'h1e, 24'h540000);
      lvl(0, 3'h4);
      lvl(6, 3'h2);
      wr(6'h1e, 24'h340000);
      lvl(0, 3'h2);
      lvl(6, 3'h5);
      @(posedge core_clk);
      current_source_select <= 4'h4;
      lvl(0, 3'h4);
      lvl(6, 3'h2);
      @(posedge core_clk);
      switch_closed_pin <= 5'h0;
      lvl(6, 3'h5);
      // mid-run reset: every field and the level of input 2 must clear again
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(6'h1d, 24'h0);
      rd(6'h1e, 24'h0);
      lvl(6, 3'h0);
      close_out;
   end
endmodule
`default_nettype wire
